// File: hdl/wakeup_defines.svh
`ifndef WAKEUP_DEFINES_SVH
`define WAKEUP_DEFINES_SVH
// status register offset and bit layout
`define STATUS_ADDR 5'h08
`define ST_KEY_LSB 3
`define ST_WAKE_BIT 2
`define ST_LOWSUP_BIT 1
`define ST_AUX_BIT 0
// command byte layout
`define CMD_TYPE_MSB 7
`define CMD_TYPE_LSB 5
`define CMD_READ_REG 3'h2
`define CMD_CLR_IRQ 3'h5
// debounce length in derived-clock periods
`define DEBOUNCE_PERIODS 8195
`define DERIVED_DIGITAL_CLOCK_DIV_DEFAULT 4
`endif

// File: hdl/wakeup_pkg.sv
package wakeup_pkg;
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_ACTIVE,
    MODE_AUX
  } power_mode_t;
  typedef struct packed {
    logic key_pending;
    logic wake_set;
    logic aux_set;
  } irq_events_t;
endpackage

// File: hdl/key_debounce.sv
`timescale 1ns/1ps
`include "wakeup_defines.svh"
module key_debounce
  import wakeup_pkg::*;
#(
  parameter int KEYS = 5,
  parameter int PERIODS = `DEBOUNCE_PERIODS
)(
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic derived_digital_clock_tick_in,
  input wire logic enable_in,
  // keys, active low
  input wire logic [KEYS-1:0] key_input_n_in,
  // result
  output logic running_out,
  output logic done_out,
  output logic [KEYS-1:0] key_level_out
);
  localparam int CW = $clog2(PERIODS + 1);
  logic [KEYS-1:0] key_prev_r;
  logic [KEYS-1:0] last_key_r;
  logic [CW-1:0] count_r;
  logic running_r;
  logic done_r;
  logic [KEYS-1:0] key_level_r;
  logic [KEYS-1:0] key_event;
  logic same_key;
  logic any_event;
  logic reached;
  assign key_event = key_prev_r ^ key_input_n_in;
  assign any_event = enable_in && (key_event != '0);
  assign same_key = running_r && ((key_event & last_key_r) != '0);
  assign reached = running_r && derived_digital_clock_tick_in && (count_r == CW'(PERIODS - 1));
  assign running_out = running_r;
  // done lags reached by one edge, so the level it hands over is already registered
  assign done_out = done_r;
  assign key_level_out = key_level_r;

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      key_prev_r <= '1;
      last_key_r <= '0;
      count_r <= '0;
      running_r <= 1'b0;
      done_r <= 1'b0;
      key_level_r <= '0;
    end
    else
    begin
      key_prev_r <= key_input_n_in;
      done_r <= reached && !any_event;
      if (any_event)
      begin
        last_key_r <= key_event;
        count_r <= '0;
        // same key bounces again: stop, else restart from zero
        running_r <= !same_key;
      end
      else if (reached)
      begin
        running_r <= 1'b0;
        key_level_r <= ~key_input_n_in;
      end
      else if (running_r && derived_digital_clock_tick_in)
        count_r <= count_r + 1'b1;
    end
  end

  a_debounce_stop: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    reached && !any_event |=> !running_r && done_out) else $error("debounce did not stop");
  a_same_key_stop: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    any_event && same_key |=> !running_r && !done_out) else $error("bounce kept counting");
  a_other_restart: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    any_event && !same_key |=> running_r && count_r == '0) else $error("no restart");
endmodule

// File: hdl/wakeup_status_irq_logic.sv
`timescale 1ns/1ps
`include "wakeup_defines.svh"
module wakeup_status_irq_logic
  import wakeup_pkg::*;
#(
  parameter int KEYS = 5,
  parameter int DERIVED_DIGITAL_CLOCK_DIV = `DERIVED_DIGITAL_CLOCK_DIV_DEFAULT,
  parameter int DEBOUNCE = `DEBOUNCE_PERIODS
)(
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // wake sources
  input wire logic [KEYS-1:0] key_input_n_in,
  input wire logic wake_pin_in,
  input wire logic aux_supply_pin_in,
  input wire logic aux_qualified_in,
  // supply monitors
  input wire logic supply_good_in,
  input wire logic supply_low_in,
  input wire logic xto_settled_in,
  // control register 3 enables as written by the host
  input wire logic ext_supply_en_cfg_in,
  input wire logic clk_out_en_cfg_in,
  // decoded serial command strobe
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic [4:0] cmd_addr_in,
  input wire logic off_request_in,
  // status and host outputs
  output logic [7:0] event_status_out,
  output logic irq_out,
  output logic host_rst_n_out,
  output logic supplies_on_out,
  output logic external_supply_enable_out,
  output logic clk_out_enable_out,
  output power_mode_t mode_out
);
  localparam int DW = $clog2(DERIVED_DIGITAL_CLOCK_DIV + 1);
  power_mode_t mode_r;
  logic [DW-1:0] div_r;
  logic [KEYS-1:0] key_status_r;
  logic [KEYS-1:0] key_prev_r;
  logic wake_prev_r;
  logic aux_prev_r;
  logic wake_flag_r;
  logic low_flag_r;
  logic aux_flag_r;
  logic irq_r;
  logic host_rst_n_r;
  logic [KEYS-1:0] wake_key_r;
  logic wake_by_pin_r;
  logic wake_pending_r;
  logic [7:0] status_r;
  logic derived_digital_clock_tick;
  logic status_read;
  logic clr_cmd;
  logic [KEYS-1:0] key_fall;
  logic wake_rise;
  logic aux_rise;
  logic deb_running;
  logic deb_done;
  logic [KEYS-1:0] deb_level;
  logic in_off;
  logic active_noaux;
  logic wake_off_key;
  logic wake_off_pin;
  logic wake_off_aux;
  logic wake_set;
  logic aux_set;
  logic key_set;
  logic wake_up_done;
  irq_events_t ev;

  assign derived_digital_clock_tick = (div_r == DW'(DERIVED_DIGITAL_CLOCK_DIV - 1));
  assign status_read = cmd_valid_in
    && cmd_byte_in[`CMD_TYPE_MSB:`CMD_TYPE_LSB] == `CMD_READ_REG
    && cmd_addr_in == `STATUS_ADDR;
  assign clr_cmd = cmd_valid_in
    && cmd_byte_in[`CMD_TYPE_MSB:`CMD_TYPE_LSB] == `CMD_CLR_IRQ;
  assign key_fall = key_prev_r & ~key_input_n_in;
  assign wake_rise = wake_pin_in && !wake_prev_r;
  assign aux_rise = aux_supply_pin_in && !aux_prev_r;
  assign in_off = (mode_r == MODE_OFF);
  assign active_noaux = (mode_r == MODE_ACTIVE);
  assign wake_off_key = in_off && (key_fall != '0);
  assign wake_off_pin = in_off && wake_rise;
  assign wake_off_aux = in_off && aux_supply_pin_in;
  // key and pin wake-up events are reported once the host reset is released, i.e. logic running
  assign wake_up_done = wake_pending_r && host_rst_n_r;
  assign wake_set = (!in_off && wake_rise) || (wake_up_done && wake_by_pin_r);
  assign aux_set = (active_noaux && aux_rise && aux_qualified_in) || wake_off_aux;
  assign key_set = deb_done || (wake_up_done && wake_key_r != '0);
  assign ev.key_pending = key_set;
  assign ev.wake_set = wake_set && !wake_flag_r;
  // waking into aux always interrupts, even if the flag survived the off state
  assign ev.aux_set = (aux_set && !aux_flag_r) || wake_off_aux;

  key_debounce #(
    .KEYS(KEYS),
    .PERIODS(DEBOUNCE)
  ) u_debounce (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .derived_digital_clock_tick_in(derived_digital_clock_tick),
    .enable_in(!in_off),
    .key_input_n_in(key_input_n_in),
    .running_out(deb_running),
    .done_out(deb_done),
    .key_level_out(deb_level)
  );

  always_comb
  begin
    status_r = 8'h00;
    status_r[`ST_KEY_LSB +: KEYS] = key_status_r;
    status_r[`ST_WAKE_BIT] = wake_flag_r;
    status_r[`ST_LOWSUP_BIT] = low_flag_r;
    status_r[`ST_AUX_BIT] = aux_flag_r;
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      div_r <= '0;
    else if (derived_digital_clock_tick)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      key_prev_r <= '1;
      wake_prev_r <= 1'b0;
      aux_prev_r <= 1'b0;
    end
    else
    begin
      key_prev_r <= key_input_n_in;
      wake_prev_r <= wake_pin_in;
      aux_prev_r <= aux_supply_pin_in;
    end
  end

  // mode: only the off command leaves MODE_ACTIVE, only reset leaves MODE_AUX, a low wake pin never does
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      mode_r <= MODE_OFF;
    else if (wake_off_aux)
      mode_r <= MODE_AUX;
    else if (wake_off_key || wake_off_pin)
      mode_r <= MODE_ACTIVE;
    else if (off_request_in && !in_off && mode_r != MODE_AUX)
      mode_r <= MODE_OFF;
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wake_pending_r <= 1'b0;
      wake_by_pin_r <= 1'b0;
      wake_key_r <= '0;
    end
    else if (wake_off_key || wake_off_pin)
    begin
      wake_pending_r <= 1'b1;
      wake_by_pin_r <= wake_off_pin;
      wake_key_r <= key_fall;
    end
    else if (wake_up_done)
    begin
      wake_pending_r <= 1'b0;
      wake_by_pin_r <= 1'b0;
      wake_key_r <= '0;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      host_rst_n_r <= 1'b0;
    else if (wake_off_key || wake_off_pin || wake_off_aux)
      host_rst_n_r <= 1'b0;
    else
      host_rst_n_r <= supply_good_in && xto_settled_in;
  end

  // flags: a set in the same cycle as the clearing read wins
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      key_status_r <= '0;
      wake_flag_r <= 1'b0;
      low_flag_r <= 1'b0;
      aux_flag_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      if (deb_done)
        key_status_r <= deb_level;
      else if (wake_up_done && wake_key_r != '0)
        key_status_r <= wake_key_r;
      if (wake_set)
        wake_flag_r <= 1'b1;
      else if (status_read)
        wake_flag_r <= 1'b0;
      if (supply_low_in)
        low_flag_r <= 1'b1;
      else if (status_read && supply_good_in)
        low_flag_r <= 1'b0;
      if (aux_set)
        aux_flag_r <= 1'b1;
      else if (status_read)
        aux_flag_r <= 1'b0;
      if (ev != '0)
        irq_r <= 1'b1;
      else if (status_read || clr_cmd)
        irq_r <= 1'b0;
    end
  end

  assign event_status_out = status_r;
  assign irq_out = irq_r;
  assign host_rst_n_out = host_rst_n_r;
  assign supplies_on_out = !in_off;
  assign external_supply_enable_out = ext_supply_en_cfg_in || deb_running
    || wake_flag_r || mode_r == MODE_AUX;
  assign clk_out_enable_out = clk_out_en_cfg_in || deb_running || wake_flag_r;
  assign mode_out = mode_r;

  a_read_clears: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    status_read && !wake_set && !aux_set && ev == '0 |=> !wake_flag_r && !aux_flag_r
    && !irq_out) else $error("status read did not clear");
  a_event_irq: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    ev != '0 |=> irq_out) else $error("event without interrupt");
  a_clear_cmd: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    clr_cmd && ev == '0 |=> !irq_out) else $error("clear command ignored");
  a_key_wake: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wake_off_key && !wake_off_aux |=> mode_r == MODE_ACTIVE && !host_rst_n_out)
    else $error("key wake-up wrong");
  a_pin_wake: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wake_off_pin && !wake_off_aux |=> supplies_on_out && !host_rst_n_out)
    else $error("pin wake-up wrong");
  a_rst_gate: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    host_rst_n_out |-> $past(supply_good_in) && $past(xto_settled_in))
    else $error("host reset released early");
  a_force_en: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    deb_running || wake_flag_r |-> external_supply_enable_out && clk_out_enable_out)
    else $error("enables not forced");
  a_wake_once: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wake_flag_r && wake_rise && !key_set && !aux_set && !irq_out |=> !irq_out)
    else $error("repeat wake interrupted");
  a_low_flag: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    supply_low_in |=> event_status_out[`ST_LOWSUP_BIT]) else $error("low flag missed");
  a_aux_off: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wake_off_aux |=> mode_r == MODE_AUX && aux_flag_r && irq_out)
    else $error("aux wake-up wrong");
  a_key_status: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    deb_done |=> key_status_r == deb_level)
    else $error("key status not updated");
  a_key_bit: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wake_up_done && wake_key_r != '0 && !deb_done |=> key_status_r == $past(wake_key_r))
    else $error("wake key bit not set");
  a_pin_flag: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wake_up_done && wake_by_pin_r |=> wake_flag_r)
    else $error("wake flag not set after wake-up");
  a_wake_active: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !in_off && wake_rise |=> wake_flag_r)
    else $error("wake edge not recorded");
  a_no_pin_off: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !in_off && !off_request_in |=> !in_off)
    else $error("left active mode without off command");
  a_low_hold: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    low_flag_r && !supply_good_in |=> low_flag_r)
    else $error("low flag cleared while supply low");
  a_aux_unqual: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    active_noaux && aux_rise && !aux_qualified_in && !aux_flag_r |=> !aux_flag_r)
    else $error("unqualified aux edge set flag");
  a_irq_hold: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    irq_out && !status_read && !clr_cmd |=> irq_out)
    else $error("interrupt dropped while pending");
endmodule

// File: verification/host_cmd_model.sv
`timescale 1ns/1ps
module host_cmd_model (
  // clock
  input wire logic mclk_in,
  // requests from the bench
  input wire logic rd_req_in,
  input wire logic clr_req_in,
  input wire logic [4:0] pad_in,
  // command strobe to the device
  output logic cmd_valid_out,
  output logic [7:0] cmd_byte_out,
  output logic [4:0] cmd_addr_out
);
  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_byte_out = 8'h00;
    cmd_addr_out = 5'h00;
  end
  // idle byte and address toggle every cycle so a stale value never reads as a command
  always @(posedge mclk_in)
  begin
    cmd_valid_out <= #1 rd_req_in | clr_req_in;
    cmd_byte_out <= #1 rd_req_in ? 8'h48 : clr_req_in ? {3'h5, pad_in} : ~cmd_byte_out;
    cmd_addr_out <= #1 rd_req_in ? 5'h08 : ~cmd_addr_out;
  end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import wakeup_pkg::*;
  logic mclk_in, rst, wake, aux, auxq, good, low, crystal_oscillator, ce, ck, off_req, rd, clr;
  logic [4:0] keys, pad, caddr;
  logic cv, irq_out, host_rst_n_out, supplies_on_out, ext_en, clk_en;
  logic [7:0] cbyte, event_status_out;
  power_mode_t mode_out;
  logic [31:0] seed;
  logic [8:0] note;
  logic [8:0] q[$];
  int miscompares = 0;
  int n_checks = 0;

  wakeup_status_irq_logic #(.KEYS(5), .DERIVED_DIGITAL_CLOCK_DIV(1), .DEBOUNCE(4)) i_wakeup_status_irq_logic (
    .mclk_in(mclk_in), .sys_rst_in(rst), .key_input_n_in(keys), .wake_pin_in(wake),
    .aux_supply_pin_in(aux), .aux_qualified_in(auxq), .supply_good_in(good),
    .supply_low_in(low), .xto_settled_in(crystal_oscillator), .ext_supply_en_cfg_in(ce),
    .clk_out_en_cfg_in(ck), .cmd_valid_in(cv), .cmd_byte_in(cbyte), .cmd_addr_in(caddr),
    .off_request_in(off_req), .event_status_out(event_status_out), .irq_out(irq_out),
    .host_rst_n_out(host_rst_n_out), .supplies_on_out(supplies_on_out),
    .external_supply_enable_out(ext_en), .clk_out_enable_out(clk_en), .mode_out(mode_out));

  host_cmd_model i_host_cmd_model (.mclk_in(mclk_in), .rd_req_in(rd), .clr_req_in(clr),
    .pad_in(pad), .cmd_valid_out(cv), .cmd_byte_out(cbyte), .cmd_addr_out(caddr));

  initial
  begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic chk_bit(input string name, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s exp %b got %b", name, e, g);
    end
  endtask

  task automatic chk_status(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch event_status exp %h got %h", e, g);
    end
  endtask

  task automatic wait_irq(input logic v);
    int i;
    for (i = 0; i < 40 && irq_out !== v; i++)
      tick(1);
    chk_bit("irq_wait", v, irq_out);
    if (irq_out !== v)
      final_report();
  endtask

  // the note is queued before the request; the watcher compares as the read is taken
  task automatic read_status(input logic [7:0] s, input logic i);
    q.push_back({i, s});
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(2);
  endtask

  task automatic clr_irq();
    seed = lfsr(seed);
    pad = seed[4:0];
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(2);
  endtask

  always @(posedge mclk_in)
    if (cv === 1'b1 && cbyte[7:5] == 3'h2 && caddr == 5'h08)
    begin
      note = q.pop_front();
      chk_status(note[7:0], event_status_out);
      chk_bit("irq_at_read", note[8], irq_out);
    end

  initial
  begin
    {rst, keys, seed} = {1'b1, 5'h1F, 32'h7DCE};
    {wake, aux, auxq, good, low, crystal_oscillator, ce, ck, off_req, rd, clr, pad} = 16'h0000;
    repeat (12) @(posedge mclk_in);
    #1 rst = 1'b0;
    tick(1);
    chk_bit("host_rst_n", 1'b0, host_rst_n_out);
    chk_bit("mode_off", 1'b1, mode_out === MODE_OFF);
    keys[0] = 1'b0;
    tick(2);
    chk_bit("mode_active", 1'b1, mode_out === MODE_ACTIVE);
    chk_bit("host_rst_n", 1'b0, host_rst_n_out);
    chk_bit("supplies_on", 1'b1, supplies_on_out);
    {good, crystal_oscillator} = 2'b11;
    tick(2);
    chk_bit("host_rst_n", 1'b1, host_rst_n_out);
    wait_irq(1'b1);
    read_status(8'h08, 1'b1);
    chk_bit("irq", 1'b0, irq_out);
    $display("test key_wake done");
    keys[0] = 1'b1;
    tick(2);
    chk_bit("ext_en", 1'b1, ext_en);
    chk_bit("clk_en", 1'b1, clk_en);
    chk_bit("irq", 1'b0, irq_out);
    wait_irq(1'b1);
    read_status(8'h00, 1'b1);
    chk_bit("ext_en", 1'b0, ext_en);
    keys[1] = 1'b0;
    tick(1);
    keys[1] = 1'b1;
    tick(12);
    chk_bit("irq", 1'b0, irq_out);
    read_status(8'h00, 1'b0);
    keys[1] = 1'b0;
    tick(3);
    keys[2] = 1'b0;
    tick(3);
    chk_bit("irq", 1'b0, irq_out);
    wait_irq(1'b1);
    read_status(8'h30, 1'b1);
    keys[2:1] = 2'b11;
    wait_irq(1'b1);
    clr_irq();
    chk_bit("irq", 1'b0, irq_out);
    read_status(8'h00, 1'b0);
    $display("test debounce done");
    wake = 1'b1;
    tick(2);
    chk_bit("irq", 1'b1, irq_out);
    chk_bit("ext_en", 1'b1, ext_en);
    chk_bit("clk_en", 1'b1, clk_en);
    clr_irq();
    wake = 1'b0;
    tick(1);
    wake = 1'b1;
    tick(3);
    chk_bit("irq", 1'b0, irq_out);
    wake = 1'b0;
    tick(3);
    chk_bit("mode_active", 1'b1, mode_out === MODE_ACTIVE);
    read_status(8'h04, 1'b0);
    chk_bit("clk_en", 1'b0, clk_en);
    $display("test wake done");
    {low, good} = 2'b10;
    tick(2);
    read_status(8'h02, 1'b0);
    read_status(8'h02, 1'b0);
    {low, good} = 2'b01;
    tick(1);
    read_status(8'h02, 1'b0);
    read_status(8'h00, 1'b0);
    $display("test low_supply done");
    {aux, auxq} = 2'b10;
    tick(2);
    chk_bit("irq", 1'b0, irq_out);
    aux = 1'b0;
    tick(1);
    {aux, auxq} = 2'b11;
    tick(2);
    chk_bit("irq", 1'b1, irq_out);
    read_status(8'h01, 1'b1);
    {aux, auxq} = 2'b00;
    off_req = 1'b1;
    tick(1);
    off_req = 1'b0;
    tick(2);
    chk_bit("mode_off", 1'b1, mode_out === MODE_OFF);
    aux = 1'b1;
    tick(3);
    chk_bit("mode_aux", 1'b1, mode_out === MODE_AUX);
    wait_irq(1'b1);
    read_status(8'h01, 1'b1);
    $display("test aux done");
    {aux, good, rst} = 3'b001;
    tick(2);
    rst = 1'b0;
    tick(1);
    wake = 1'b1;
    tick(2);
    chk_bit("mode_active", 1'b1, mode_out === MODE_ACTIVE);
    chk_bit("host_rst_n", 1'b0, host_rst_n_out);
    good = 1'b1;
    wait_irq(1'b1);
    read_status(8'h04, 1'b1);
    $display("test wake_from_off done");
    final_report();
  end
endmodule
